// ===== src/imurb_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "imurb_consts.svh"

// Behaviour
// - Bits 6 and 7 enable storing accelerometer and gyroscope axes in FIFO; reset zero.
// - Per-axis clip flag set if any contributing raw sample was 0x8001 or 0xFFFF.
// - Clip flags refresh in the same update as the sensor data registers.
// - Auxiliary target address sits in bits 7..1, resetting to 0x10.
// - Automatic read burst code maps 0,1,2,3 to 1,2,6,8 bytes; resets to 3.
// - Manual read burst code in bits 3..2, same mapping, resets to 0.
// - Bit 7 set means host-triggered auxiliary access; clear means periodic sequencer.
// - In manual mode writing the read-address register starts one read; reset 0x42.
// - In manual mode writing the write-address register starts one write, except while a write is starting or running; reset 0x4C.
// - Auxiliary write byte held in its own register, resetting to 0x02.
// - Bit 6 makes the sequencer also issue a trigger write on the auxiliary port.
// - Error source joins the error interrupt only when its mask bit is one; source bit 5 never joins.
// - Each pin applies own level, drive type, output enable and input enable.
// - Latch bit zero gives non-latched interrupts; one holds them latched.
// - Bits 0..3 route full, watermark, ready, error to pin a; 4..7 to pin b.
// - Startup command 0x00 accepts an image; 0x01 enables features after loading.
// - Image base address is low bits 3..0 and high bits 7..0, twelve bits.
// - Image bytes arrive through one 8-bit data port register.
// - Read-only engine flags: bit 1 overtime, bit 2 fatal, bit 4 engine disabled.
module imurb_bank (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic link_clk_i,
   input wire logic link_srst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic raw_valid_i,
   input wire logic [2:0] raw_axis_i,
   input wire logic [15:0] raw_value_i,
   input wire logic filt_update_i,
   output logic sample_commit_o,
   output logic fifo_acc_store_o,
   output logic fifo_gyr_store_o,
   output logic [6:0] aux_target_addr_o,
   output logic [7:0] aux_rd_addr_o,
   output logic [7:0] aux_wr_addr_o,
   output logic [7:0] aux_wr_data_o,
   output logic [3:0] aux_burst_len_o,
   output logic aux_rd_start_o,
   output logic aux_wr_start_o,
   input wire logic aux_done_i,
   input wire logic [7:0] fault_sources_i,
   input wire logic [2:0] engine_fault_i,
   input wire logic queue_full_i,
   input wire logic queue_level_i,
   input wire logic sample_ready_i,
   input wire logic irq_clear_i,
   output logic irq_pin_a_o,
   output logic irq_pin_a_oe_o,
   input wire logic irq_pin_a_i,
   output logic irq_pin_a_in_o,
   output logic irq_pin_b_o,
   output logic irq_pin_b_oe_o,
   input wire logic irq_pin_b_i,
   output logic irq_pin_b_in_o,
   output logic image_mode_o,
   output logic features_on_o,
   output logic image_wr_o,
   output logic [12:0] image_addr_o,
   output logic [7:0] image_data_o
);

   logic [7:0] fifo_src_reg, clip_reg, aux_tgt_reg, aux_conf_reg, aux_rd_reg;
   logic [7:0] aux_wr_reg, aux_data_reg, fault_sel_reg, pin_a_reg, pin_b_reg;
   logic [7:0] hold_reg, feat_a_reg, feat_b_reg, route_reg, startup_reg;
   logic [7:0] base_lo_reg, base_hi_reg, img_data_reg, eng_fault_reg;
   logic manual_reg;
   logic [7:0] rdata_next;

   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = reg_wr_i && (reg_addr_i == off);
   endfunction

   function automatic logic [3:0] burst_bytes(input logic [1:0] code);
      case (code)
         2'h0: burst_bytes = 4'h1;
         2'h1: burst_bytes = 4'h2;
         2'h2: burst_bytes = 4'h6;
         default: burst_bytes = 4'h8;
      endcase
   endfunction

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fifo_src_reg <= `IMURB_RST_FIFO_SRC;
         aux_tgt_reg <= `IMURB_RST_AUX_TGT;
         aux_conf_reg <= `IMURB_RST_AUX_CONF;
         aux_rd_reg <= `IMURB_RST_AUX_RD;
         aux_wr_reg <= `IMURB_RST_AUX_WR;
         aux_data_reg <= `IMURB_RST_AUX_DATA;
         fault_sel_reg <= `IMURB_RST_ZERO;
         pin_a_reg <= `IMURB_RST_ZERO;
         pin_b_reg <= `IMURB_RST_ZERO;
         hold_reg <= `IMURB_RST_ZERO;
         feat_a_reg <= `IMURB_RST_ZERO;
         feat_b_reg <= `IMURB_RST_ZERO;
         route_reg <= `IMURB_RST_ZERO;
         startup_reg <= `IMURB_RST_ZERO;
         base_lo_reg <= `IMURB_RST_ZERO;
         base_hi_reg <= `IMURB_RST_ZERO;
         img_data_reg <= `IMURB_RST_ZERO;
      end else begin
         if (wr_hit(`IMURB_OFF_FIFO_SRC)) fifo_src_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_AUX_TGT)) aux_tgt_reg <= {reg_wdata_i[7:1], 1'b0};
         if (wr_hit(`IMURB_OFF_AUX_CONF)) aux_conf_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_AUX_RD)) aux_rd_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_AUX_WR)) aux_wr_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_AUX_DATA)) aux_data_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_FAULT_SEL)) fault_sel_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_PIN_A)) pin_a_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_PIN_B)) pin_b_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_HOLD)) hold_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_FEAT_A)) feat_a_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_FEAT_B)) feat_b_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_ROUTE)) route_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_STARTUP)) startup_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_BASE_LO)) base_lo_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_BASE_HI)) base_hi_reg <= reg_wdata_i;
         if (wr_hit(`IMURB_OFF_IMG_DATA)) img_data_reg <= reg_wdata_i;
      end
   end

   assign manual_reg = aux_conf_reg[`IMURB_BIT_MANUAL];
   assign fifo_acc_store_o = fifo_src_reg[`IMURB_BIT_ACC_STORE];
   assign fifo_gyr_store_o = fifo_src_reg[`IMURB_BIT_GYR_STORE];
   assign aux_target_addr_o = aux_tgt_reg[7:1];
   assign aux_rd_addr_o = aux_rd_reg;
   assign aux_wr_addr_o = aux_wr_reg;
   assign aux_wr_data_o = aux_data_reg;

   // Register read port, answered one cycle after the strobe
   always_comb begin
      case (reg_addr_i)
         `IMURB_OFF_FIFO_SRC: rdata_next = fifo_src_reg;
         `IMURB_OFF_CLIP: rdata_next = clip_reg;
         `IMURB_OFF_AUX_TGT: rdata_next = aux_tgt_reg;
         `IMURB_OFF_AUX_CONF: rdata_next = aux_conf_reg;
         `IMURB_OFF_AUX_RD: rdata_next = aux_rd_reg;
         `IMURB_OFF_AUX_WR: rdata_next = aux_wr_reg;
         `IMURB_OFF_AUX_DATA: rdata_next = aux_data_reg;
         `IMURB_OFF_FAULT_SEL: rdata_next = fault_sel_reg;
         `IMURB_OFF_PIN_A: rdata_next = pin_a_reg;
         `IMURB_OFF_PIN_B: rdata_next = pin_b_reg;
         `IMURB_OFF_HOLD: rdata_next = hold_reg;
         `IMURB_OFF_FEAT_A: rdata_next = feat_a_reg;
         `IMURB_OFF_FEAT_B: rdata_next = feat_b_reg;
         `IMURB_OFF_ROUTE: rdata_next = route_reg;
         `IMURB_OFF_STARTUP: rdata_next = startup_reg;
         `IMURB_OFF_BASE_LO: rdata_next = base_lo_reg;
         `IMURB_OFF_BASE_HI: rdata_next = base_hi_reg;
         `IMURB_OFF_IMG_DATA: rdata_next = img_data_reg;
         `IMURB_OFF_ENG_FAULT: rdata_next = eng_fault_reg;
         default: rdata_next = `IMURB_RST_ZERO;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) reg_rdata_o <= `IMURB_RST_ZERO;
      else if (reg_rd_i) reg_rdata_o <= rdata_next;
   end

   // Clip detection on the link clock; flags gather between filtered updates
   logic [5:0] clip_hit, clip_acc_reg, clip_snap_reg;
   logic link_tgl_reg, tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_axis
         assign clip_hit[g] = raw_valid_i && (raw_axis_i == 3'(g)) &&
            (raw_value_i == `IMURB_SAT_NEG || raw_value_i == `IMURB_SAT_POS);
         always_ff @(posedge link_clk_i) begin
            if (link_srst_i) clip_acc_reg[g] <= 1'b0;
            else if (filt_update_i) clip_acc_reg[g] <= 1'b0;
            else if (clip_hit[g]) clip_acc_reg[g] <= 1'b1;
         end
      end
   endgenerate

   always_ff @(posedge link_clk_i) begin
      if (link_srst_i) begin
         clip_snap_reg <= 6'h00;
         link_tgl_reg <= 1'b0;
      end else if (filt_update_i) begin
         clip_snap_reg <= clip_acc_reg | clip_hit;
         link_tgl_reg <= ~link_tgl_reg;
      end
   end

   // Toggle crossing; the snapshot is held still until the next update
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
      end else begin
         tgl_s1_reg <= link_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
      end
   end

   // Flags and the data-register commit share one edge; host writes never land here
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         clip_reg <= `IMURB_RST_ZERO;
         sample_commit_o <= 1'b0;
      end else begin
         sample_commit_o <= tgl_s2_reg ^ tgl_s3_reg;
         if (tgl_s2_reg ^ tgl_s3_reg) clip_reg <= {2'b00, clip_snap_reg};
      end
   end

   // Engine fault flags follow the engine, read-only
   always_ff @(posedge clk_i) begin
      if (srst_i) eng_fault_reg <= `IMURB_RST_ZERO;
      else begin
         eng_fault_reg <= `IMURB_RST_ZERO;
         eng_fault_reg[`IMURB_BIT_ERR_LONG] <= engine_fault_i[0];
         eng_fault_reg[`IMURB_BIT_ERR_FATAL] <= engine_fault_i[1];
         eng_fault_reg[`IMURB_BIT_ERR_FEAT] <= engine_fault_i[2];
      end
   end

   // Auxiliary sequencer
   imurb_pkg::imurb_aux_state_type aux_state_reg, aux_state_next;
   logic rd_pend_reg, wr_pend_reg, poll_due;
   logic [15:0] poll_cnt_reg;
   logic host_rd, host_wr;

   // Spelled out: a continuous assignment does not wake on signals read inside a function
   assign host_rd = reg_wr_i && reg_addr_i == `IMURB_OFF_AUX_RD && manual_reg;
   assign host_wr = reg_wr_i && reg_addr_i == `IMURB_OFF_AUX_WR && manual_reg;
   assign poll_due = !manual_reg && (poll_cnt_reg == 16'h0000);

   always_comb begin
      aux_state_next = aux_state_reg;
      case (aux_state_reg)
         imurb_pkg::IMURB_IDLE: begin
            if (manual_reg) begin
               if (wr_pend_reg) aux_state_next = imurb_pkg::IMURB_WRITE;
               else if (rd_pend_reg) aux_state_next = imurb_pkg::IMURB_READ;
            end else if (poll_due) begin
               aux_state_next = aux_conf_reg[`IMURB_BIT_TRIG_WR] ?
                  imurb_pkg::IMURB_WRITE : imurb_pkg::IMURB_READ;
            end
         end
         imurb_pkg::IMURB_WRITE: begin
            if (aux_done_i) aux_state_next = manual_reg ?
               imurb_pkg::IMURB_IDLE : imurb_pkg::IMURB_READ;
         end
         imurb_pkg::IMURB_READ: begin
            if (aux_done_i) aux_state_next = imurb_pkg::IMURB_IDLE;
         end
         default: aux_state_next = imurb_pkg::IMURB_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) aux_state_reg <= imurb_pkg::IMURB_IDLE;
      else aux_state_reg <= aux_state_next;
   end

   // A read trigger that arrives as its pending flag is consumed is kept; a write trigger is lost while the write runs
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rd_pend_reg <= 1'b0;
         wr_pend_reg <= 1'b0;
      end else begin
         if (host_rd) rd_pend_reg <= 1'b1;
         else if (manual_reg && aux_state_next == imurb_pkg::IMURB_READ &&
                  aux_state_reg == imurb_pkg::IMURB_IDLE) rd_pend_reg <= 1'b0;
         else if (!manual_reg) rd_pend_reg <= 1'b0;
         if (host_wr) wr_pend_reg <= 1'b1;
         else if (manual_reg && aux_state_next == imurb_pkg::IMURB_WRITE) wr_pend_reg <= 1'b0;
         else if (!manual_reg) wr_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) poll_cnt_reg <= 16'(`IMURB_AUX_POLL_CYC - 1);
      else if (manual_reg || poll_cnt_reg == 16'h0000) begin
         if (aux_state_reg == imurb_pkg::IMURB_IDLE)
            poll_cnt_reg <= 16'(`IMURB_AUX_POLL_CYC - 1);
      end else poll_cnt_reg <= poll_cnt_reg - 16'h0001;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         aux_rd_start_o <= 1'b0;
         aux_wr_start_o <= 1'b0;
         aux_burst_len_o <= 4'h0;
      end else begin
         aux_rd_start_o <= aux_state_next == imurb_pkg::IMURB_READ &&
                           aux_state_reg != imurb_pkg::IMURB_READ;
         aux_wr_start_o <= aux_state_next == imurb_pkg::IMURB_WRITE &&
                           aux_state_reg != imurb_pkg::IMURB_WRITE;
         if (aux_state_next == imurb_pkg::IMURB_READ && aux_state_reg != imurb_pkg::IMURB_READ)
            aux_burst_len_o <= manual_reg ? burst_bytes(aux_conf_reg[3:2])
                                          : burst_bytes(aux_conf_reg[1:0]);
      end
   end

   // Interrupt pins; index 0 is pin a, 1 is pin b
   logic fault_irq;
   logic [7:0] pin_cfg [2];
   logic [1:0] src_act, held_reg, pin_assert, pin_val_reg, pin_oe_reg;
   logic [1:0] pin_in, in_s1_reg, in_s2_reg, in_en_reg;

   assign fault_irq = |(fault_sources_i & fault_sel_reg & 8'hdf);
   assign pin_cfg[0] = pin_a_reg;
   assign pin_cfg[1] = pin_b_reg;
   assign pin_in = {irq_pin_b_i, irq_pin_a_i};

   generate
      for (g = 0; g < 2; g++) begin : g_pin
         assign src_act[g] = |({fault_irq, sample_ready_i, queue_level_i, queue_full_i}
                                & route_reg[4*g +: 4]);
         assign pin_assert[g] = src_act[g] | (hold_reg[`IMURB_BIT_LATCH] & held_reg[g]);
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               held_reg[g] <= 1'b0;
               pin_val_reg[g] <= 1'b1;
               pin_oe_reg[g] <= 1'b0;
               in_s1_reg[g] <= 1'b0;
               in_s2_reg[g] <= 1'b0;
               in_en_reg[g] <= 1'b0;
            end else begin
               if (src_act[g] && hold_reg[`IMURB_BIT_LATCH]) held_reg[g] <= 1'b1;
               else if (irq_clear_i || !hold_reg[`IMURB_BIT_LATCH]) held_reg[g] <= 1'b0;
               pin_val_reg[g] <= pin_assert[g] ~^ pin_cfg[g][`IMURB_BIT_LEVEL];
               // Open drain never drives high; the pull-up makes the level
               pin_oe_reg[g] <= pin_cfg[g][`IMURB_BIT_OUT_EN] &&
                  !(pin_cfg[g][`IMURB_BIT_DRIVE] &&
                    (pin_assert[g] ~^ pin_cfg[g][`IMURB_BIT_LEVEL]));
               in_s1_reg[g] <= pin_in[g];
               in_s2_reg[g] <= in_s1_reg[g];
               in_en_reg[g] <= in_s2_reg[g] & pin_cfg[g][`IMURB_BIT_IN_EN];
            end
         end
      end
   endgenerate

   assign irq_pin_a_o = pin_val_reg[0];
   assign irq_pin_b_o = pin_val_reg[1];
   assign irq_pin_a_oe_o = pin_oe_reg[0];
   assign irq_pin_b_oe_o = pin_oe_reg[1];
   assign irq_pin_a_in_o = in_en_reg[0];
   assign irq_pin_b_in_o = in_en_reg[1];

   // Startup and image loading; the byte counter restarts whenever the base moves
   logic [12:0] img_cnt_reg;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         image_mode_o <= 1'b0;
         features_on_o <= 1'b0;
      end else if (wr_hit(`IMURB_OFF_STARTUP)) begin
         if (reg_wdata_i == `IMURB_CMD_LOAD) begin
            image_mode_o <= 1'b1;
            features_on_o <= 1'b0;
         end else if (reg_wdata_i == `IMURB_CMD_START) begin
            image_mode_o <= 1'b0;
            features_on_o <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         img_cnt_reg <= 13'h0000;
         image_wr_o <= 1'b0;
         image_addr_o <= 13'h0000;
         image_data_o <= 8'h00;
      end else begin
         image_wr_o <= wr_hit(`IMURB_OFF_IMG_DATA) && image_mode_o;
         if (wr_hit(`IMURB_OFF_BASE_LO) || wr_hit(`IMURB_OFF_BASE_HI)) img_cnt_reg <= 13'h0000;
         else if (wr_hit(`IMURB_OFF_IMG_DATA) && image_mode_o) begin
            image_addr_o <= {base_hi_reg, base_lo_reg[3:0], 1'b0} + img_cnt_reg;
            image_data_o <= reg_wdata_i;
            img_cnt_reg <= img_cnt_reg + 13'h0001;
         end
      end
   end

   // Checks
   sequence s_manual_rd_req;
      reg_wr_i && reg_addr_i == `IMURB_OFF_AUX_RD && manual_reg &&
      aux_state_reg == imurb_pkg::IMURB_IDLE && !wr_pend_reg;
   endsequence
   sequence s_rd_issued;
      ##[2:3] aux_rd_start_o;
   endsequence

   fifo_store_a: assert property (@(posedge clk_i) disable iff (srst_i)
      reg_wr_i && reg_addr_i == `IMURB_OFF_FIFO_SRC |=>
      fifo_acc_store_o == $past(reg_wdata_i[6]) && fifo_gyr_store_o == $past(reg_wdata_i[7]))
      else $error("fifo store enable not taken from write");
   clip_detect_a: assert property (@(posedge link_clk_i) disable iff (link_srst_i)
      raw_valid_i && raw_axis_i == 3'h4 && raw_value_i == 16'h8001 && !filt_update_i
      |=> clip_acc_reg[4])
      else $error("clip code not caught");
   clip_commit_a: assert property (@(posedge clk_i) disable iff (srst_i)
      $changed(clip_reg) |-> sample_commit_o)
      else $error("clip flags moved without commit");
   target_addr_a: assert property (@(posedge clk_i) disable iff (srst_i)
      reg_wr_i && reg_addr_i == `IMURB_OFF_AUX_TGT |=> aux_target_addr_o == $past(reg_wdata_i[7:1]))
      else $error("target address not stored");
   auto_burst_a: assert property (@(posedge clk_i) disable iff (srst_i)
      aux_rd_start_o && !manual_reg && aux_conf_reg[1:0] == 2'h2 |-> aux_burst_len_o == 4'h6)
      else $error("automatic burst length wrong");
   manual_idle_a: assert property (@(posedge clk_i) disable iff (srst_i)
      manual_reg && !rd_pend_reg && !wr_pend_reg && !host_rd && !host_wr &&
      aux_state_reg == imurb_pkg::IMURB_IDLE |=> !aux_rd_start_o && !aux_wr_start_o)
      else $error("manual mode access without trigger");
   manual_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
      s_manual_rd_req |-> s_rd_issued)
      else $error("manual read not started");
   trig_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
      aux_wr_start_o && !manual_reg |-> aux_state_reg == imurb_pkg::IMURB_WRITE ##1
      (aux_state_reg == imurb_pkg::IMURB_WRITE || aux_state_reg == imurb_pkg::IMURB_READ))
      else $error("trigger write sequence broken");
   fault_mask_a: assert property (@(posedge clk_i) disable iff (srst_i)
      fault_sel_reg == 8'h00 |-> !fault_irq)
      else $error("masked fault reached interrupt");
   open_drain_a: assert property (@(posedge clk_i) disable iff (srst_i)
      pin_a_reg[`IMURB_BIT_DRIVE] && $stable(pin_a_reg) && irq_pin_a_o |-> !irq_pin_a_oe_o)
      else $error("open drain pin driven high");
   latch_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
      hold_reg[0] && $stable(hold_reg) && held_reg[0] && !irq_clear_i |=> held_reg[0])
      else $error("latched interrupt dropped");
   startup_cmd_a: assert property (@(posedge clk_i) disable iff (srst_i)
      reg_wr_i && reg_addr_i == `IMURB_OFF_STARTUP && reg_wdata_i == 8'h01
      |=> features_on_o && !image_mode_o)
      else $error("start command not applied");

endmodule // imurb_bank

`default_nettype wire

// ===== src/imurb_consts.svh
`ifndef IMURB_CONSTS_SVH
`define IMURB_CONSTS_SVH

// Register offsets
`define IMURB_OFF_FIFO_SRC 8'h49
`define IMURB_OFF_CLIP 8'h4a
`define IMURB_OFF_AUX_TGT 8'h4b
`define IMURB_OFF_AUX_CONF 8'h4c
`define IMURB_OFF_AUX_RD 8'h4d
`define IMURB_OFF_AUX_WR 8'h4e
`define IMURB_OFF_AUX_DATA 8'h4f
`define IMURB_OFF_FAULT_SEL 8'h52
`define IMURB_OFF_PIN_A 8'h53
`define IMURB_OFF_PIN_B 8'h54
`define IMURB_OFF_HOLD 8'h55
`define IMURB_OFF_FEAT_A 8'h56
`define IMURB_OFF_FEAT_B 8'h57
`define IMURB_OFF_ROUTE 8'h58
`define IMURB_OFF_STARTUP 8'h59
`define IMURB_OFF_BASE_LO 8'h5b
`define IMURB_OFF_BASE_HI 8'h5c
`define IMURB_OFF_IMG_DATA 8'h5e
`define IMURB_OFF_ENG_FAULT 8'h5f

// Reset values
`define IMURB_RST_FIFO_SRC 8'h10
`define IMURB_RST_AUX_TGT 8'h20
`define IMURB_RST_AUX_CONF 8'h83
`define IMURB_RST_AUX_RD 8'h42
`define IMURB_RST_AUX_WR 8'h4c
`define IMURB_RST_AUX_DATA 8'h02
`define IMURB_RST_ZERO 8'h00

// Field positions
`define IMURB_BIT_ACC_STORE 6
`define IMURB_BIT_GYR_STORE 7
`define IMURB_BIT_TRIG_WR 6
`define IMURB_BIT_MANUAL 7
`define IMURB_BIT_LEVEL 1
`define IMURB_BIT_DRIVE 2
`define IMURB_BIT_OUT_EN 3
`define IMURB_BIT_IN_EN 4
`define IMURB_BIT_LATCH 0
`define IMURB_BIT_ERR_LONG 1
`define IMURB_BIT_ERR_FATAL 2
`define IMURB_BIT_ERR_FEAT 4
`define IMURB_ENG_FAULT_MASK 8'h16

// Startup commands and saturation codes
`define IMURB_CMD_LOAD 8'h00
`define IMURB_CMD_START 8'h01
`define IMURB_SAT_NEG 16'h8001
`define IMURB_SAT_POS 16'hffff

// Automatic auxiliary poll period
`define IMURB_AUX_POLL_NS 40000
`define IMURB_CLK_NS 40
`define IMURB_AUX_POLL_CYC (`IMURB_AUX_POLL_NS / `IMURB_CLK_NS)

`endif

// ===== src/imurb_pkg.sv
package imurb_pkg;
   typedef enum logic [1:0] {
      IMURB_IDLE = 2'b00,
      IMURB_WRITE = 2'b01,
      IMURB_READ = 2'b11
   } imurb_aux_state_type;
endpackage

// ===== dv/imurb_aux_model.sv
`timescale 1ns/10ps
`default_nettype none
module imurb_aux_model #(parameter int LAT = 3) (
   input wire logic clk_i,
   input wire logic start_i,
   output logic done_o
);
   int cnt = 0;
   initial done_o = 1'b0;
   // Slow enough that a trigger arriving mid-access must wait
   always @(posedge clk_i) begin
      done_o <= (cnt == 1);
      if (start_i)
         cnt <= LAT;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
endmodule // imurb_aux_model
`default_nettype wire

// ===== dv/test_imurb_bank.sv
`timescale 1ns/10ps
`default_nettype none
module test_imurb_bank;
   logic clk_i = 0, srst_i = 1, link_clk_i = 0, link_srst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic raw_valid_i = 0, filt_update_i = 0, queue_full_i = 0, queue_level_i = 0;
   logic sample_ready_i = 0, irq_clear_i = 0, aux_done_i, sample_commit_o, image_wr_o;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, fault_sources_i = 8'h00, reg_rdata_o;
   logic [2:0] raw_axis_i = 3'h0, engine_fault_i = 3'h0;
   logic [15:0] raw_value_i = 16'h0000;
   logic fifo_acc_store_o, fifo_gyr_store_o, aux_rd_start_o, aux_wr_start_o;
   logic irq_pin_a_o, irq_pin_a_oe_o, irq_pin_a_in_o, irq_pin_b_o, irq_pin_b_oe_o;
   logic irq_pin_b_in_o, image_mode_o, features_on_o;
   logic [6:0] aux_target_addr_o;
   logic [7:0] aux_rd_addr_o, aux_wr_addr_o, aux_wr_data_o, image_data_o;
   logic [3:0] aux_burst_len_o;
   logic [12:0] image_addr_o;
   logic [20:0] img_last = 21'h0;
   // Pins carry a pull-up when nobody drives them
   wire logic irq_pin_a_i = irq_pin_a_oe_o ? irq_pin_a_o : 1'b1;
   wire logic irq_pin_b_i = irq_pin_b_oe_o ? irq_pin_b_o : 1'b1;
   wire logic aux_go = aux_rd_start_o | aux_wr_start_o;
   wire logic [3:0] pin_view = {irq_pin_a_o, irq_pin_a_oe_o, irq_pin_b_o, irq_pin_b_oe_o};
   int error_cnt = 0, n_checks = 0;
   imurb_bank imurb_bank_inst (.*);
   imurb_aux_model imurb_aux_model_inst (.clk_i(clk_i), .start_i(aux_go), .done_o(aux_done_i));
   initial forever #20 clk_i = ~clk_i;
   initial begin
      #7;
      forever #24 link_clk_i = ~link_clk_i;
   end
   always @(posedge clk_i) if (image_wr_o === 1'b1) img_last <= {image_addr_o, image_data_o};
   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      chk(21'(reg_rdata_o), 21'(e));
   endtask
   task automatic wait_hi(const ref logic s, input int n);
      for (int k = 0; k < n; k++) begin
         @(negedge clk_i);
         if (s === 1'b1) break;
      end
      chk(21'(s), 21'h1);
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      srst_i <= 1'b0;
      link_srst_i <= 1'b0;
      rd(8'h4b, 8'h20);
      rd(8'h4c, 8'h83);
      rd(8'h4d, 8'h42);
      rd(8'h4e, 8'h4c);
      rd(8'h4f, 8'h02);
      chk(21'(aux_target_addr_o), 21'h10);
      wr(8'h49, 8'hc0);
      engine_fault_i <= 3'b111;
      @(negedge clk_i);
      chk(21'({fifo_gyr_store_o, fifo_acc_store_o}), 21'h3);
      wr(8'h4a, 8'hff);
      wr(8'h5f, 8'h00);
      rd(8'h5f, 8'h16);
      chk(21'(reg_rdata_o & 8'h16), 21'h16);
      rd(8'h4a, 8'h00);
      rd(8'h50, 8'h00);
      $display("test registers done");
      wr(8'h4c, 8'h88);
      wr(8'h4d, 8'h5a);
      wait_hi(aux_rd_start_o, 20);
      chk(21'({aux_burst_len_o, aux_rd_addr_o}), 21'h65a);
      wr(8'h4f, 8'h3c);
      wr(8'h4e, 8'h11);
      wait_hi(aux_wr_start_o, 20);
      chk(21'({aux_wr_addr_o, aux_wr_data_o}), 21'h113c);
      wr(8'h4c, 8'h42);
      wait_hi(aux_wr_start_o, 1100);
      wait_hi(aux_rd_start_o, 40);
      chk(21'(aux_burst_len_o), 21'h6);
      wr(8'h4c, 8'h80);
      $display("test aux done");
      @(posedge link_clk_i);
      raw_valid_i <= 1'b1;
      raw_value_i <= 16'hffff;
      @(posedge link_clk_i);
      raw_axis_i <= 3'h4;
      raw_value_i <= 16'h8001;
      @(posedge link_clk_i);
      raw_valid_i <= 1'b0;
      filt_update_i <= 1'b1;
      @(posedge link_clk_i);
      filt_update_i <= 1'b0;
      wait_hi(sample_commit_o, 20);
      rd(8'h4a, 8'h11);
      $display("test clip done");
      wr(8'h58, 8'h44);
      wr(8'h53, 8'h0a);
      wr(8'h54, 8'h0c);
      sample_ready_i <= 1'b1;
      repeat (3) @(negedge clk_i);
      chk(21'(pin_view), 21'hd);
      @(posedge clk_i);
      sample_ready_i <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk(21'(pin_view), 21'h6);
      wr(8'h52, 8'hff);
      wr(8'h58, 8'h08);
      fault_sources_i <= 8'h20;
      repeat (3) @(negedge clk_i);
      chk(21'(irq_pin_a_o), 21'h0);
      @(posedge clk_i);
      fault_sources_i <= 8'h80;
      repeat (3) @(negedge clk_i);
      chk(21'(irq_pin_a_o), 21'h1);
      wr(8'h52, 8'h00);
      repeat (2) @(negedge clk_i);
      chk(21'(irq_pin_a_o), 21'h0);
      wr(8'h53, 8'h1e);
      wr(8'h54, 8'h10);
      wr(8'h58, 8'h04);
      wr(8'h55, 8'h01);
      sample_ready_i <= 1'b1;
      @(posedge clk_i);
      sample_ready_i <= 1'b0;
      repeat (4) @(negedge clk_i);
      chk(21'(pin_view), 21'ha);
      chk(21'({irq_pin_a_in_o, irq_pin_b_in_o}), 21'h3);
      @(posedge clk_i);
      irq_clear_i <= 1'b1;
      @(posedge clk_i);
      irq_clear_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk(21'(pin_view), 21'h6);
      $display("test pins done");
      wr(8'h59, 8'h00);
      wr(8'h5b, 8'h03);
      wr(8'h5c, 8'h12);
      wr(8'h5e, 8'ha5);
      repeat (3) @(negedge clk_i);
      chk(img_last, {13'h0246, 8'ha5});
      wr(8'h5e, 8'h5a);
      repeat (2) @(negedge clk_i);
      chk(img_last, {13'h0247, 8'h5a});
      wr(8'h5b, 8'h04);
      wr(8'h5e, 8'hc3);
      repeat (2) @(negedge clk_i);
      chk(img_last, {13'h0248, 8'hc3});
      wr(8'h59, 8'h01);
      repeat (2) @(negedge clk_i);
      chk(21'({image_mode_o, features_on_o}), 21'h1);
      $display("test image done");
      finish_test();
   end
endmodule // test_imurb_bank
`default_nettype wire
